/* File: ecl_child_ctx_leaves.sv */
// Leaf engine for child-count increment and context set, with an AHB-Lite register slave.
`include "ecl_defs.svh"
`default_nettype none
// Overview of operation
// [RULE1] Both leaves run only at privilege zero.
// [RULE2] Accumulator one selects increment when feature supported.
// [RULE3] Accumulator two selects context set when supported.
// [RULE4] Linear addresses come from data segment only.
// [RULE5] Unaligned target page raises protection fault.
// [RULE6] Operand outside page cache raises enclave fault.
// [RULE7] Busy target page returns conflict, sets zero.
// [RULE8] Invalid target page raises enclave page fault.
// [RULE9] Parent from page map, own address, else fault.
// [RULE10] Parent mismatch with structure raises protection fault.
// [RULE11] Count overflow rolls back, sets zero, invalid code.
// [RULE12] Success clears zero flag, accumulator gets zero.
// [RULE13] Increment completion clears arithmetic status flags.
// [RULE14] Unusable segment or beyond limit faults, 32-bit.
// [RULE15] Non-canonical address faults in 64-bit mode.
// [RULE16] Memory access page fault reported normally.
// [RULE17] Only target page is checked for conflicts.
// [RULE18] Other leaves never cause a conflict here.
// [RULE19] Software gives structure and context addresses.
// [RULE20] Context field overwritten; creation sets own address.
// [RULE21] Context set fails: misaligned or not structure.
// [RULE22] Context set needs 4K and 8-byte alignment.
// [RULE23] Context set completion clears arithmetic status flags.
// [RULE24] Context set: invalid/wrong type faults, else stores.
// [RULE25] Faults leave count, context, accumulator unchanged.
module ecl_child_ctx_leaves
    import ecl_pkg::*;
#(
    parameter int          VA_BITS       = 48,
    parameter logic [31:0] CONFLICT_CODE = 32'h0000_0010,
    parameter logic [31:0] INVALID_CODE  = 32'h0000_0011
) (
    input  wire logic        clock,
    input  wire logic        reset,
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic      [31:0] hrdata,
    output logic             hreadyout,
    output logic             hresp
);

    logic         addrPhase;
    logic         wrPend_q;
    logic         rdPend_q;
    logic [7:0]   busAddr_q;
    logic [31:0]  hrdata_q;
    logic         hreadyout_q;
    logic         hresp_q;
    logic [31:0]  readMux;
    logic [7:0]   wordOff;
    logic [3:0]   wordIdx;
    logic         inWords;
    logic         regWrOk;
    logic [31:0]  word_q [`ECL_NUM_WORDS];
    ecl_env_t     env_q;
    logic [31:0]  dsBase_q;
    logic [31:0]  dsLimit_q;
    logic [31:0]  acc_q;
    logic [5:0]   flags_q;
    logic [63:0]  count_q;
    logic [63:0]  ctx_q;
    ecl_status_t  status_q;
    ecl_state_t   state_q;
    ecl_outcome_t outcome_d;
    ecl_outcome_t outcome_q;
    logic         startReq;
    logic         initReq;
    logic         isInc;
    logic         isCtx;
    logic [63:0]  baseOff;
    logic [63:0]  countOff;
    logic [63:0]  dataOff;
    logic [63:0]  linBase;
    logic [63:0]  linCount;
    logic [63:0]  linData;
    logic [63:0]  parentMap;
    logic [63:0]  parentAddr;
    logic [63:0]  ctxVal;
    logic         segFault;
    logic         typeOk;
    logic         cntFull;

    // AHB-Lite slave. Reads take one wait state so a write in the previous data phase is seen.
    assign addrPhase = hsel && htrans[1] && hready;
    assign regWrOk   = wrPend_q && !status_q.busy;
    assign wordOff   = busAddr_q - `ECL_ADDR_WORD0;
    assign wordIdx   = wordOff[5:2];
    assign inWords   = busAddr_q >= `ECL_ADDR_WORD0 && busAddr_q <= `ECL_ADDR_WORDN;

    always_ff @(posedge clock) begin
        if (reset) begin
            wrPend_q    <= 1'b0;
            rdPend_q    <= 1'b0;
            busAddr_q   <= 8'h00;
            hreadyout_q <= 1'b1;
            hrdata_q    <= 32'h0;
            hresp_q     <= 1'b0;
        end else begin
            wrPend_q    <= addrPhase && hwrite;
            rdPend_q    <= addrPhase && !hwrite;
            hreadyout_q <= !(addrPhase && !hwrite);
            hresp_q     <= 1'b0;
            if (addrPhase) begin
                busAddr_q <= haddr[7:0];
            end
            if (rdPend_q) begin
                hrdata_q <= readMux;
            end
        end
    end

    assign hrdata    = hrdata_q;
    assign hreadyout = hreadyout_q;
    assign hresp     = hresp_q;

    always_comb begin
        readMux = 32'h0;
        if (busAddr_q == `ECL_ADDR_ACC) begin
            readMux = acc_q;
        end else if (busAddr_q == `ECL_ADDR_CMD) begin
            readMux = {26'h0, status_q};
        end else if (inWords) begin
            readMux = word_q[wordIdx];
        end else if (busAddr_q == `ECL_ADDR_ENV) begin
            readMux = {{(32 - $bits(ecl_env_t)){1'b0}}, env_q};
        end else if (busAddr_q == `ECL_ADDR_DSBASE) begin
            readMux = dsBase_q;
        end else if (busAddr_q == `ECL_ADDR_DSLIM) begin
            readMux = dsLimit_q;
        end else if (busAddr_q == `ECL_ADDR_FLAGS) begin
            readMux = {26'h0, flags_q};
        end else if (busAddr_q == `ECL_ADDR_CNT_LO) begin
            readMux = count_q[31:0];
        end else if (busAddr_q == `ECL_ADDR_CNT_HI) begin
            readMux = count_q[63:32];
        end else if (busAddr_q == `ECL_ADDR_CTX_LO) begin
            readMux = ctx_q[31:0];
        end else if (busAddr_q == `ECL_ADDR_CTX_HI) begin
            readMux = ctx_q[63:32];
        end
    end

    // Operand words are frozen while a leaf runs, so checks and effects see one set of inputs.
    for (genvar i = 0; i < `ECL_NUM_WORDS; i++) begin : g_word
        always_ff @(posedge clock) begin
            if (reset) begin
                word_q[i] <= 32'h0;
            end else if (regWrOk && inWords && wordIdx == 4'(i)) begin
                word_q[i] <= hwdata;
            end
        end
    end

    always_ff @(posedge clock) begin
        if (reset) begin
            env_q     <= '0;
            dsBase_q  <= 32'h0;
            dsLimit_q <= 32'h0;
        end else if (regWrOk) begin
            if (busAddr_q == `ECL_ADDR_ENV) begin
                env_q <= ecl_env_t'(hwdata[$bits(ecl_env_t)-1:0]);
            end else if (busAddr_q == `ECL_ADDR_DSBASE) begin
                dsBase_q <= hwdata;
            end else if (busAddr_q == `ECL_ADDR_DSLIM) begin
                dsLimit_q <= hwdata;
            end
        end
    end

    assign startReq = regWrOk && busAddr_q == `ECL_ADDR_CMD && hwdata[`ECL_CMD_START];
    assign initReq  = regWrOk && busAddr_q == `ECL_ADDR_CMD && hwdata[`ECL_CMD_INIT];

    // Address formation and operand checks.
    function automatic logic [63:0] linAddr(input logic [63:0] off, input logic m64, input logic [31:0] base);
        logic [31:0] lin32;
        lin32 = base + off[31:0];
        return m64 ? off : {32'h0, lin32};
    endfunction

    function automatic logic badSeg(input logic [63:0] off, input ecl_env_t env, input logic [31:0] lim);
        if (env.mode64) begin
            return off[63:VA_BITS-1] != {(65 - VA_BITS){off[63]}};
        end
        return !env.dsUsable || off[31:0] > lim;
    endfunction

    assign isInc     = acc_q == `ECL_LEAF_INC;
    assign isCtx     = acc_q == `ECL_LEAF_CTX;
    assign baseOff   = {word_q[`ECL_W_BASE + 4'h1], word_q[`ECL_W_BASE]};
    assign countOff  = {word_q[`ECL_W_COUNT + 4'h1], word_q[`ECL_W_COUNT]};
    assign dataOff   = {word_q[`ECL_W_DATA + 4'h1], word_q[`ECL_W_DATA]};
    assign parentMap = {word_q[`ECL_W_PARENT + 4'h1], word_q[`ECL_W_PARENT]};
    // No override input exists: every operand is offset into the data segment.
    assign linBase   = linAddr(baseOff, env_q.mode64, dsBase_q);  // [RULE4]
    assign linCount  = linAddr(countOff, env_q.mode64, dsBase_q); // [RULE4]
    assign linData   = linAddr(dataOff, env_q.mode64, dsBase_q);  // [RULE4]
    // [RULE14] [RULE15]
    assign segFault  = badSeg(isInc ? baseOff : dataOff, env_q, dsLimit_q) || badSeg(countOff, env_q, dsLimit_q);
    assign typeOk    = env_q.pageType inside {`ECL_REGULAR_PAGE_TYPE, `ECL_THREAD_CONTROL_PAGE_TYPE, `ECL_TRIMMED_PAGE_TYPE, `ECL_CONTROL_STRUCTURE_PAGE_TYPE}; // [RULE9]
    // Physical addresses equal linear ones here; a structure page is its own parent.
    assign parentAddr = env_q.pageType == `ECL_CONTROL_STRUCTURE_PAGE_TYPE ? linBase : parentMap; // [RULE9]
    assign cntFull   = &count_q;
    assign ctxVal    = {word_q[`ECL_W_CTXVAL + 4'h1], word_q[`ECL_W_CTXVAL]};

    always_comb begin
        outcome_d = ECL_OUT_REFUSE;
        if (!env_q.featureOn || env_q.privLevel != 2'h0 || !(isInc || isCtx)) begin
            outcome_d = ECL_OUT_REFUSE; // [RULE1] [RULE2] [RULE3]
        end else if (segFault) begin
            outcome_d = ECL_OUT_GP; // [RULE14] [RULE15]
        end else if (env_q.memFault) begin
            outcome_d = ECL_OUT_PF_MEM; // [RULE16]
        end else if (isInc) begin
            if ((linBase[11:0] & `ECL_PAGE_MASK) != 12'h0) begin
                outcome_d = ECL_OUT_GP; // [RULE5]
            end else if (!env_q.targetInCache || !env_q.structInCache) begin
                outcome_d = ECL_OUT_PF_ENC; // [RULE6]
            end else if (env_q.targetBusy) begin
                // The structure operand is shared, and other leaves never count as a conflict.
                outcome_d = ECL_OUT_CONFLICT; // [RULE7] [RULE17] [RULE18]
            end else if (!env_q.targetValid) begin
                outcome_d = ECL_OUT_PF_ENC; // [RULE8]
            end else if (!typeOk) begin
                outcome_d = ECL_OUT_PF_ENC; // [RULE9]
            end else if (parentAddr != linCount) begin
                outcome_d = ECL_OUT_GP; // [RULE10]
            end else begin
                outcome_d = ECL_OUT_INC;
            end
        end else begin
            if ((linCount[11:0] & `ECL_PAGE_MASK) != 12'h0) begin
                outcome_d = ECL_OUT_GP; // [RULE21] [RULE22]
            end else if (!env_q.structInCache) begin
                outcome_d = ECL_OUT_PF_ENC;
            end else if ((linData[2:0] & `ECL_CTX_MASK) != 3'h0) begin
                outcome_d = ECL_OUT_GP; // [RULE22]
            end else if (env_q.targetBusy) begin
                outcome_d = ECL_OUT_CONFLICT; // [RULE17]
            end else if (!env_q.targetValid || env_q.pageType != `ECL_CONTROL_STRUCTURE_PAGE_TYPE) begin
                outcome_d = ECL_OUT_PF_ENC; // [RULE21] [RULE24]
            end else begin
                outcome_d = ECL_OUT_CTX;
            end
        end
    end

    // Sequencer: one cycle to decide, one to apply, so the count update is a single edge.
    always_ff @(posedge clock) begin
        if (reset) begin
            state_q <= ECL_IDLE;
        end else begin
            case (state_q)
                ECL_IDLE: begin
                    if (startReq) begin
                        state_q <= ECL_CHECK;
                    end
                end
                ECL_CHECK: state_q <= ECL_UPDATE;
                ECL_UPDATE: state_q <= ECL_IDLE;
                default: state_q <= ECL_IDLE;
            endcase
        end
    end

    always_ff @(posedge clock) begin
        if (reset) begin
            outcome_q <= ECL_OUT_REFUSE;
        end else if (state_q == ECL_CHECK) begin
            outcome_q <= outcome_d;
        end
    end

    always_ff @(posedge clock) begin
        if (reset) begin
            status_q <= '0;
        end else if (startReq) begin
            status_q      <= '0;
            status_q.busy <= 1'b1;
        end else if (state_q == ECL_UPDATE) begin
            status_q.busy      <= 1'b0;
            status_q.done      <= 1'b1;
            status_q.refused   <= outcome_q == ECL_OUT_REFUSE;
            status_q.gpFault   <= outcome_q == ECL_OUT_GP;
            status_q.pfFault   <= outcome_q inside {ECL_OUT_PF_ENC, ECL_OUT_PF_MEM};
            status_q.pfEnclave <= outcome_q == ECL_OUT_PF_ENC; // [RULE6]
        end
    end

    // A faulting or refused leaf leaves the accumulator alone.
    always_ff @(posedge clock) begin
        if (reset) begin
            acc_q <= `ECL_ACC_RST;
        end else if (state_q == ECL_UPDATE) begin
            if (outcome_q == ECL_OUT_CONFLICT) begin
                acc_q <= CONFLICT_CODE; // [RULE7]
            end else if (outcome_q == ECL_OUT_INC) begin
                acc_q <= cntFull ? INVALID_CODE : 32'h0; // [RULE11] [RULE12]
            end else if (outcome_q == ECL_OUT_CTX) begin
                acc_q <= 32'h0; // [RULE24]
            end
        end else if (regWrOk && busAddr_q == `ECL_ADDR_ACC) begin
            acc_q <= hwdata;
        end
    end

    // Incrementing an all-ones count and rolling it back leaves it unchanged.
    always_ff @(posedge clock) begin
        if (reset) begin
            count_q <= 64'h0;
        end else if (state_q == ECL_UPDATE) begin
            if (outcome_q == ECL_OUT_INC && !cntFull) begin
                count_q <= count_q + 64'h1; // [RULE11] [RULE25]
            end
        end else if (regWrOk && busAddr_q == `ECL_ADDR_CNT_LO) begin
            count_q[31:0] <= hwdata;
        end else if (regWrOk && busAddr_q == `ECL_ADDR_CNT_HI) begin
            count_q[63:32] <= hwdata;
        end
    end

    always_ff @(posedge clock) begin
        if (reset) begin
            ctx_q <= 64'h0;
        end else if (state_q == ECL_UPDATE && outcome_q == ECL_OUT_CTX) begin
            ctx_q <= ctxVal; // [RULE20] [RULE24]
        end else if (initReq) begin
            ctx_q <= linCount; // [RULE20]
        end
    end

    always_ff @(posedge clock) begin
        if (reset) begin
            flags_q <= `ECL_FLAGS_RST;
        end else if (state_q == ECL_UPDATE && outcome_q inside {ECL_OUT_CONFLICT, ECL_OUT_INC, ECL_OUT_CTX}) begin
            flags_q <= flags_q & ~`ECL_FLAGS_ARITH; // [RULE13] [RULE23]
            flags_q[`ECL_FLAG_ZF] <= outcome_q == ECL_OUT_CONFLICT || (outcome_q == ECL_OUT_INC && cntFull); // [RULE12]
        end else if (regWrOk && busAddr_q == `ECL_ADDR_FLAGS) begin
            flags_q <= hwdata[5:0];
        end
    end

    sequence s_apply(ecl_outcome_t o);
        state_q == ECL_UPDATE && outcome_q == o;
    endsequence

    sequence s_finished;
        state_q == ECL_IDLE && status_q.done && !status_q.busy;
    endsequence

    a_priv_refuse: assert property (@(posedge clock) disable iff (reset) // [RULE1]
        state_q == ECL_CHECK && env_q.privLevel != 2'h0 |-> ##2 (s_finished and status_q.refused && $stable(acc_q)))
        else $error("leaf ran outside privilege zero");

    a_feature_gate: assert property (@(posedge clock) disable iff (reset) // [RULE2]
        state_q == ECL_CHECK && !env_q.featureOn |-> ##2 status_q.refused && !status_q.gpFault)
        else $error("leaf ran without feature support");

    a_leaf_select: assert property (@(posedge clock) disable iff (reset) // [RULE3]
        state_q == ECL_CHECK && !isInc && !isCtx |-> ##2 status_q.refused && $stable(ctx_q))
        else $error("unknown leaf selector not refused");

    a_page_align: assert property (@(posedge clock) disable iff (reset) // [RULE5]
        state_q == ECL_CHECK && isInc && outcome_d != ECL_OUT_REFUSE && !segFault && !env_q.memFault
        && linBase[11:0] != 12'h0 |-> ##2 status_q.gpFault && !status_q.pfFault)
        else $error("unaligned target page not faulted");

    a_canon_check: assert property (@(posedge clock) disable iff (reset) // [RULE15]
        state_q == ECL_CHECK && env_q.mode64 && outcome_d != ECL_OUT_REFUSE
        && baseOff[63:VA_BITS-1] != {(65 - VA_BITS){baseOff[63]}} && isInc |-> ##2 status_q.gpFault)
        else $error("non-canonical operand not faulted");

    a_conflict_code: assert property (@(posedge clock) disable iff (reset) // [RULE7]
        s_apply(ECL_OUT_CONFLICT) |=> acc_q == CONFLICT_CODE && flags_q[`ECL_FLAG_ZF] && $stable(count_q))
        else $error("conflict not reported");

    a_count_wrap: assert property (@(posedge clock) disable iff (reset) // [RULE11]
        s_apply(ECL_OUT_INC) and cntFull |=> $stable(count_q) && acc_q == INVALID_CODE && flags_q[`ECL_FLAG_ZF])
        else $error("counter overflow mishandled");

    a_count_step: assert property (@(posedge clock) disable iff (reset) // [RULE12]
        s_apply(ECL_OUT_INC) and !cntFull |=> count_q == $past(count_q) + 64'h1 && acc_q == 32'h0
        && !flags_q[`ECL_FLAG_ZF])
        else $error("increment result wrong");

    a_flags_clear: assert property (@(posedge clock) disable iff (reset) // [RULE13]
        state_q == ECL_UPDATE && outcome_q inside {ECL_OUT_CONFLICT, ECL_OUT_INC, ECL_OUT_CTX}
        |=> (flags_q & `ECL_FLAGS_ARITH) == 6'h00)
        else $error("status flags not cleared");

    a_ctx_store: assert property (@(posedge clock) disable iff (reset) // [RULE24]
        s_apply(ECL_OUT_CTX) |=> ctx_q == $past(ctxVal) && acc_q == 32'h0 && !flags_q[`ECL_FLAG_ZF])
        else $error("context value not stored");

    a_fault_hold: assert property (@(posedge clock) disable iff (reset) // [RULE25]
        state_q == ECL_UPDATE && outcome_q inside {ECL_OUT_GP, ECL_OUT_PF_ENC, ECL_OUT_PF_MEM}
        |=> $stable(count_q) && $stable(ctx_q) && $stable(acc_q) && $stable(flags_q))
        else $error("fault changed architectural state");

endmodule // ecl_child_ctx_leaves
`default_nettype wire

/* File: ecl_defs.svh */
// Register offsets, field positions, codes and reset values for the enclave leaf engine.
`ifndef ECL_DEFS_SVH
`define ECL_DEFS_SVH

`define ECL_ADDR_ACC     8'h00
`define ECL_ADDR_CMD     8'h04
`define ECL_ADDR_WORD0   8'h08
`define ECL_ADDR_WORDN   8'h2c
`define ECL_ADDR_ENV     8'h30
`define ECL_ADDR_DSBASE  8'h34
`define ECL_ADDR_DSLIM   8'h38
`define ECL_ADDR_FLAGS   8'h3c
`define ECL_ADDR_CNT_LO  8'h40
`define ECL_ADDR_CNT_HI  8'h44
`define ECL_ADDR_CTX_LO  8'h48
`define ECL_ADDR_CTX_HI  8'h4c

`define ECL_NUM_WORDS    10
`define ECL_W_BASE       4'h0
`define ECL_W_COUNT      4'h2
`define ECL_W_DATA       4'h4
`define ECL_W_PARENT     4'h6
`define ECL_W_CTXVAL     4'h8

`define ECL_CMD_START    0
`define ECL_CMD_INIT     1

`define ECL_LEAF_INC     32'h0000_0001
`define ECL_LEAF_CTX     32'h0000_0002

`define ECL_REGULAR_PAGE_TYPE       3'h0
`define ECL_THREAD_CONTROL_PAGE_TYPE       3'h1
`define ECL_TRIMMED_PAGE_TYPE      3'h2
`define ECL_CONTROL_STRUCTURE_PAGE_TYPE      3'h3

`define ECL_FLAG_ZF      5
`define ECL_FLAGS_ARITH  6'h1f
`define ECL_FLAGS_RST    6'h00
`define ECL_ACC_RST      32'h0000_0000
`define ECL_PAGE_MASK    12'hfff
`define ECL_CTX_MASK     3'h7

`endif

/* File: ecl_pkg.sv */
// Types shared by the enclave leaf engine.
`default_nettype none
package ecl_pkg;

    typedef enum logic [2:0] {
        ECL_IDLE   = 3'b001,
        ECL_CHECK  = 3'b010,
        ECL_UPDATE = 3'b100
    } ecl_state_t;

    typedef enum logic [6:0] {
        ECL_OUT_REFUSE   = 7'b0000001,
        ECL_OUT_GP       = 7'b0000010,
        ECL_OUT_PF_ENC   = 7'b0000100,
        ECL_OUT_PF_MEM   = 7'b0001000,
        ECL_OUT_CONFLICT = 7'b0010000,
        ECL_OUT_INC      = 7'b0100000,
        ECL_OUT_CTX      = 7'b1000000
    } ecl_outcome_t;

    typedef struct packed {
        logic       memFault;
        logic [2:0] pageType;
        logic       targetValid;
        logic       targetBusy;
        logic       structInCache;
        logic       targetInCache;
        logic       featureOn;
        logic       dsUsable;
        logic       mode64;
        logic [1:0] privLevel;
    } ecl_env_t;

    typedef struct packed {
        logic pfEnclave;
        logic pfFault;
        logic gpFault;
        logic refused;
        logic done;
        logic busy;
    } ecl_status_t;

endpackage
`default_nettype wire

/* File: tb_ecl_child_ctx_leaves.sv */
// Self-checking bench for the enclave leaf engine, driven over its register bus.
`include "ecl_defs.svh"
`default_nettype none
module tb_ecl_child_ctx_leaves;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [31:0] ENVG = 32'h0000_017c;
    localparam logic [31:0] ENVC = 32'h0000_077c;
    logic        clock = 1'b0;
    logic        reset = 1'b1;
    logic        hsel = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [1:0]  htrans = 2'h0;
    logic        hwrite = 1'b0;
    logic [2:0]  hsize = 3'h2;
    logic [31:0] hwdata = 32'h0;
    logic [31:0] hrdata;
    logic        hreadyout;
    logic        hresp;
    logic [31:0] v;
    int          fail_count = 0;
    int          compares = 0;
    // Operand words from base LO up to context value HI, all in the passing state.
    logic [31:0] goodV [10] = '{32'h1_0000, 32'h0, 32'h2_0000, 32'h0, 32'h8, 32'h0, 32'h2_0000, 32'h0,
                                32'h9abc_def0, 32'h1234_5678};

    always #20 clock = ~clock;

    ecl_child_ctx_leaves dut (.clock(clock), .reset(reset), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
        .hreadyout(hreadyout), .hresp(hresp));

    task automatic summarize;
        $display("compares=%0d fail_count=%0d", compares, fail_count);
        if (fail_count == 0 && compares > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    // The address phase is held until hready is seen high, so a wait state never drops a request.
    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
        hsel   <= 1'b1;
        haddr  <= {24'h0, a};
        htrans <= 2'h2;
        hwrite <= w;
        do @(posedge clock); while (hreadyout !== 1'b1);
        hsel   <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge clock); while (hreadyout !== 1'b1);
        v = hrdata;
    endtask

    task automatic chk(input logic [7:0] a, input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            fail_count++;
            $display("unexpected reg %h expected %h seen %h", a, exp, seen);
        end
    endtask

    task automatic rchk(input logic [7:0] a, input logic [31:0] exp, input logic [31:0] m = 32'hffff_ffff);
        xfer(1'b0, a, 32'h0);
        chk(a, v & m, exp);
    endtask

    // The optional poke lands a count write while the leaf is busy; it must be dropped.
    task automatic run(input logic [31:0] sel, input logic poke = 1'b0);
        int n;
        xfer(1'b1, `ECL_ADDR_ACC, sel);
        xfer(1'b1, `ECL_ADDR_CMD, 32'h1);
        if (poke) xfer(1'b1, `ECL_ADDR_CNT_LO, 32'h99);
        n = 0;
        do begin
            xfer(1'b0, `ECL_ADDR_CMD, 32'h0);
            n++;
        end while (v[0] !== 1'b0 && n < 10);
        if (v[0] !== 1'b0) fail_count++;
    endtask

    task automatic good;
        for (int i = 0; i < 10; i++) xfer(1'b1, 8'h08 + 8'(4 * i), goodV[i]);
        xfer(1'b1, `ECL_ADDR_DSBASE, 32'h0);
        xfer(1'b1, `ECL_ADDR_DSLIM, 32'hffff_ffff);
    endtask

    task automatic fault(input logic [31:0] sel, input logic [31:0] env, input logic [7:0] a,
                         input logic [31:0] d, input logic [31:0] st);
        good();
        xfer(1'b1, `ECL_ADDR_ENV, env);
        xfer(1'b1, a, d);
        run(sel);
        rchk(`ECL_ADDR_CMD, st, 32'h3c);
        rchk(`ECL_ADDR_ACC, sel);
        rchk(`ECL_ADDR_FLAGS, 32'h3f);
        rchk(`ECL_ADDR_CNT_LO, 32'h7);
        rchk(`ECL_ADDR_CTX_LO, 32'h2_0000);
    endtask

    initial begin
        #400000;
        fail_count++;
        summarize();
    end

    initial begin
        repeat (4) @(posedge clock);
        reset <= 1'b0;
        @(posedge clock);
        rchk(`ECL_ADDR_FLAGS, 32'h0);
        rchk(`ECL_ADDR_CNT_LO, 32'h0);
        rchk(8'h50, 32'h0);
        good();
        xfer(1'b1, `ECL_ADDR_ENV, ENVG);
        xfer(1'b1, `ECL_ADDR_CNT_LO, 32'h5);
        xfer(1'b1, `ECL_ADDR_FLAGS, 32'h3f);
        run(`ECL_LEAF_INC, 1'b1);
        rchk(`ECL_ADDR_ACC, 32'h0);
        rchk(`ECL_ADDR_FLAGS, 32'h0);
        rchk(`ECL_ADDR_CNT_LO, 32'h6);
        xfer(1'b1, `ECL_ADDR_ENV, ENVG | 32'h80);
        run(`ECL_LEAF_INC);
        rchk(`ECL_ADDR_ACC, 32'h10);
        rchk(`ECL_ADDR_FLAGS, 32'h20);
        rchk(`ECL_ADDR_CNT_LO, 32'h6);
        xfer(1'b1, `ECL_ADDR_ENV, ENVC);
        xfer(1'b1, `ECL_ADDR_WORD0, 32'h2_0000);
        run(`ECL_LEAF_INC);
        rchk(`ECL_ADDR_CNT_LO, 32'h7);
        good();
        xfer(1'b1, `ECL_ADDR_CMD, 32'h2);
        rchk(`ECL_ADDR_CTX_LO, 32'h2_0000);
        xfer(1'b1, `ECL_ADDR_FLAGS, 32'h3f);
        fault(`ECL_LEAF_INC, ENVG | 32'h1, `ECL_ADDR_DSBASE, 32'h0, 32'h04);
        fault(`ECL_LEAF_INC, 32'h16c, `ECL_ADDR_DSBASE, 32'h0, 32'h04);
        fault(32'h3, ENVG, `ECL_ADDR_DSBASE, 32'h0, 32'h04);
        fault(`ECL_LEAF_INC, ENVG, `ECL_ADDR_WORD0, 32'h1_0008, 32'h08);
        fault(`ECL_LEAF_INC, 32'h15c, `ECL_ADDR_DSBASE, 32'h0, 32'h30);
        fault(`ECL_LEAF_INC, 32'h13c, `ECL_ADDR_DSBASE, 32'h0, 32'h30);
        fault(`ECL_LEAF_INC, 32'h07c, `ECL_ADDR_DSBASE, 32'h0, 32'h30);
        fault(`ECL_LEAF_INC, 32'hb7c, `ECL_ADDR_DSBASE, 32'h0, 32'h30);
        fault(`ECL_LEAF_INC, ENVG, 8'h20, 32'h3_0000, 32'h08);
        fault(`ECL_LEAF_INC, 32'h117c, `ECL_ADDR_DSBASE, 32'h0, 32'h10);
        fault(`ECL_LEAF_INC, ENVG, 8'h0c, 32'h1_0000, 32'h08);
        fault(`ECL_LEAF_INC, 32'h170, `ECL_ADDR_DSBASE, 32'h0, 32'h08);
        fault(`ECL_LEAF_INC, 32'h178, `ECL_ADDR_DSLIM, 32'h1000, 32'h08);
        fault(`ECL_LEAF_INC, 32'h178, `ECL_ADDR_DSBASE, 32'h1000, 32'h08);
        fault(`ECL_LEAF_CTX, ENVC, 8'h10, 32'h2_0100, 32'h08);
        fault(`ECL_LEAF_CTX, ENVC, 8'h18, 32'hc, 32'h08);
        fault(`ECL_LEAF_CTX, ENVG, `ECL_ADDR_DSBASE, 32'h0, 32'h30);
        fault(`ECL_LEAF_CTX, 32'h67c, `ECL_ADDR_DSBASE, 32'h0, 32'h30);
        good();
        xfer(1'b1, `ECL_ADDR_ENV, ENVC);
        run(`ECL_LEAF_CTX);
        rchk(`ECL_ADDR_ACC, 32'h0);
        rchk(`ECL_ADDR_FLAGS, 32'h0);
        rchk(`ECL_ADDR_CTX_LO, 32'h9abc_def0);
        rchk(`ECL_ADDR_CTX_HI, 32'h1234_5678);
        rchk(`ECL_ADDR_CNT_LO, 32'h7);
        xfer(1'b1, `ECL_ADDR_ENV, ENVG);
        xfer(1'b1, `ECL_ADDR_CNT_LO, 32'hffff_ffff);
        xfer(1'b1, `ECL_ADDR_CNT_HI, 32'hffff_ffff);
        run(`ECL_LEAF_INC);
        rchk(`ECL_ADDR_ACC, 32'h11);
        rchk(`ECL_ADDR_FLAGS, 32'h20);
        rchk(`ECL_ADDR_CNT_LO, 32'hffff_ffff);
        rchk(`ECL_ADDR_CNT_HI, 32'hffff_ffff);
        chk(8'h00, {31'h0, hresp}, 32'h0);
        summarize();
    end
endmodule // tb_ecl_child_ctx_leaves
`default_nettype wire
